// ===== dv/drd_checker.sv
`timescale 1ns/1ns
module drd_checker
  import drd_pkg::*;
#(
  parameter int LAT  = DRD_SKEW_LAT,  // skew correction latency
  parameter int SW_C = DRD_SW         // core sample width
) (
  input wire logic                      sys_clk,   // sample clock
  input wire logic                      rst_b,     // reset, active low
  input wire drd_apb_req_t              apb_req,   // apb request
  input wire logic                      pready,    // apb ready
  input wire logic [31:0]               prdata,    // apb read data
  input wire logic                      pslverr,   // apb error
  input wire logic                      in_valid,  // sample strobe
  input wire logic signed [SW_C-1:0]    in_a,      // channel 1 or i
  input wire logic signed [SW_C-1:0]    in_b,      // channel 2 or q
  input wire logic                      out_valid, // output strobe
  input wire logic signed [SW_C+1:0]    out_a,     // chain a word
  input wire logic signed [SW_C+1:0]    out_b      // chain b word
);
  localparam int D = LAT + 1;  // input to output cycles with skew on
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // taken access answers on the very next edge
  a_apb_answer_time: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("apb answer not one cycle after access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_misalign_err: assert property (pready && !apb_req.pwrite && apb_req.paddr[1:0] != 2'b00
    |-> pslverr && prdata == 32'h0)
    else $error("misaligned read not refused");
  a_read_upper_zero: assert property (pready && !apb_req.pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_prdata_hold: assert property (!pready |-> $stable(prdata))
    else $error("read data moved outside answer");
  // every output strobe follows an input either directly or after the skew delay
  a_out_has_cause: assert property (out_valid |-> $past(in_valid) || $past(in_valid, D))
    else $error("output strobe without matching input");
  a_out_data_held: assert property (!out_valid |-> $stable(out_a) && $stable(out_b))
    else $error("output data changed without strobe");
  c_skew_path: cover property (out_valid && $past(in_valid, D) && !$past(in_valid));
  c_refused: cover property (pslverr);
  c_write: cover property (pready && apb_req.pwrite);
endmodule : drd_checker

// ===== dv/drd_core_src.sv
`timescale 1ns/1ns
module drd_core_src
  import drd_pkg::*;
(
  input  wire logic                     sys_clk,  // sample clock
  input  wire logic                     rst_b,    // reset, active low
  input  wire logic [9:0]               burst,    // samples to send, one-cycle load
  input  wire logic signed [DRD_SW-1:0] a_val,    // channel 1 or i value
  input  wire logic signed [DRD_SW-1:0] b_val,    // channel 2 or q value
  output logic                          in_valid, // sample strobe
  output logic signed [DRD_SW-1:0]      in_a,     // channel 1 or i data
  output logic signed [DRD_SW-1:0]      in_b      // channel 2 or q data
);
  logic [9:0] left;  // samples still owed
  // back-to-back samples; idle lines flip so stale data never looks valid
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      left     <= '0;
      in_valid <= 1'b0;
      in_a     <= '0;
      in_b     <= '0;
    end else begin
      in_valid <= (left != 10'h000);
      if (burst != 10'h000) begin  // load a new burst
        left <= burst;
      end else if (left != 10'h000) begin  // count down
        left <= left - 10'h001;
      end
      if (left != 10'h000) begin  // sending
        in_a <= a_val;
        in_b <= b_val;
      end else begin  // idle: toggle
        in_a <= ~in_a;
        in_b <= ~in_b;
      end
    end
  end
endmodule : drd_core_src

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb;
  import drd_pkg::*;
  localparam int LAT_T = 4;  // shortened skew latency
  localparam logic [7:0] IX [6] = '{DRD_IDX_RES, DRD_IDX_DUAL, DRD_IDX_SKA,
                                    DRD_IDX_AHI, DRD_IDX_CHB, DRD_IDX_SEL};
  logic                            sys_clk = 1'b0;  // sample clock
  logic                            rst_b = 1'b0;    // reset
  drd_apb_req_t                    apb_req = '0;    // bus request
  logic                            pready, pslverr, in_valid, out_valid;
  logic [31:0]                     prdata, rd;      // read data, last taken
  logic                            err;             // last response error
  logic signed [DRD_SW-1:0]        in_a, in_b;      // stream in
  logic signed [DRD_SW+DRD_XB-1:0] out_a, out_b;    // stream out
  logic [9:0]                      burst = '0;      // burst request to source
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int outs, lat;
  always #2 sys_clk = ~sys_clk;
  drd_top #(.LAT(LAT_T)) DUT (.*);
  drd_core_src src (.*, .a_val(16'sh1234), .b_val(-16'sh1234));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is seen, hang guard ends a stuck wait
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask : wr
  task automatic rdi(input logic [7:0] i);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
  endtask : rdi
  // send n samples, count strobes and first latency
  task automatic run(input int n);
    int fi;
    fi = -1;
    lat = -1;
    outs = 0;
    @(posedge sys_clk);
    burst <= n[9:0];
    @(posedge sys_clk);
    burst <= '0;
    for (int i = 0; i < n + LAT_T + 20; i++) begin
      @(posedge sys_clk);
      if (in_valid === 1'b1 && fi < 0) fi = i;
      if (out_valid === 1'b1) begin
        outs++;
        if (lat < 0) lat = i - fi;
      end
    end
  endtask : run
  // register reset, readback, refusals
  task automatic t_regs;
    foreach (IX[k]) begin
      rdi(IX[k]);
      chk("reset value", rd, 32'h0);
      wr(IX[k], 32'ha5);
      rdi(IX[k]);
      chk("readback", rd, 32'ha5);
      wr(IX[k], 32'h0);
    end
    rdi(DRD_IDX_MODE);
    chk("mode reset", rd, 32'h10);
    rdi(8'h00);
    chk("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h1ea, 32'h0);
    chk("misaligned err", {31'h0, err}, 32'h1);
    chk("misaligned data", rd, 32'h0);
    wr(DRD_IDX_STAT, 32'h1f);
    rdi(DRD_IDX_STAT);
    chk("status read only", rd, 32'h0);
  endtask : t_regs
  // single mode: chain a only, skew never applies
  task automatic t_single;
    logic [8:0] th;
    for (int k = 0; k <= 9; k += 3) begin
      th = 9'((1 << k) - 1);
      wr(DRD_IDX_SKA, {24'h0, k == 0, 6'h0, th[0]});
      wr(DRD_IDX_AHI, {24'h0, th[8:1]});
      if (k == 9) wr(DRD_IDX_RES, 32'h1); // extra lsbs only at high rate
      run(1 << k);
      chk("outputs per n", outs, 1);
      if (k == 9) chk("wide word", out_a, 32'h48d0);
      rdi(DRD_IDX_STAT);
      chk("stage count", rd, k);
      if (k == 0) chk("bypass latency", lat, 1);
    end
    wr(DRD_IDX_SKA, 32'h0);
    wr(DRD_IDX_AHI, 32'h0);
    wr(DRD_IDX_RES, 32'h0);
  endtask : t_single
  // dual mode: both chains, skew first, rate cap, band
  task automatic t_dual;
    wr(DRD_IDX_MODE, 32'h11);
    wr(DRD_IDX_DUAL, 32'h1);
    wr(DRD_IDX_SKA, 32'h80);
    wr(DRD_IDX_AHI, 32'h1);
    run(4);
    chk("pair outputs", outs, 2);
    chk("skew then halve", lat, LAT_T + 2);
    chk("i on chain a", {31'h0, out_a[17]}, 32'h0);
    chk("q on chain b", {31'h0, out_b[17]}, 32'h1);
    wr(DRD_IDX_AHI, 32'hff);
    rdi(DRD_IDX_STAT);
    chk("dual stages", rd, 32'h18);
    wr(DRD_IDX_AHI, 32'h0);
    for (int b = 0; b < 2; b++) begin
      wr(DRD_IDX_SEL, b << 2);
      run(1);
      chk("dual skew latency", lat, LAT_T + 1);
    end
    wr(DRD_IDX_DUAL, 32'h0);
    run(1);
    chk("not routed", lat, 1);
  endtask : t_dual
  // octal mode: octal variant and route
  task automatic t_octal;
    wr(DRD_IDX_MODE, 32'h12);
    wr(DRD_IDX_SEL, 32'h3);
    run(1);
    chk("octal skew latency", lat, LAT_T + 1);
    wr(DRD_IDX_SEL, 32'h1);
    run(1);
    chk("octal unrouted", lat, 1);
  endtask : t_octal
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs;
    t_single;
    t_dual;
    t_octal;
    complete_run;
  end
endmodule : tb
bind drd_top drd_checker #(.LAT(LAT), .SW_C(SW)) u_chk (.*);

// ===== include/drd_pkg.sv
// Contract
// - skew correction only in dual or octal
// - skew correction adds exactly 59 cycles latency
// - skew correction precedes all other processing
// - variant bit 0 selects dual-channel correction
// - variant bit 1 selects octal-channel correction
// - channel-count bit routes processing dual or octal
// - dual processing enable turns on dual processing
// - band bit picks first or second band
// - decimation in single, dual, CW octal modes
// - chain A/B fields thermometer coded, one per stage; chain_b_stages unused, chain B stages follow chain_a_high
// - each enabled stage halves the sample rate
// - single mode: chain A only, up to 512x
// - dual or I/Q: both chains, same rate
// - dual mode decimation at most 256x
// - extra LSB bit gives 18-bit output words; here only in 16-bit output mode
// - I data to chain A, Q to chain B
package drd_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] DRD_IDX_RES   = 8'h68;  // output_resolution_control
  localparam logic [7:0] DRD_IDX_DUAL  = 8'h79;  // dual_processing_enable
  localparam logic [7:0] DRD_IDX_SKA   = 8'h7a;  // skew_fix_and_chain_a_low
  localparam logic [7:0] DRD_IDX_AHI   = 8'h7b;  // chain_a_high
  localparam logic [7:0] DRD_IDX_CHB   = 8'h7c;  // chain_b_stages
  localparam logic [7:0] DRD_IDX_SEL   = 8'h81;  // skew_fix_mode_select
  localparam logic [7:0] DRD_IDX_MODE  = 8'h82;  // operating mode
  localparam logic [7:0] DRD_IDX_STAT  = 8'h83;  // read-only status
  // field positions
  localparam int DRD_B_XLSB    = 0;  // extra_lsb_enable in 0x68
  localparam int DRD_B_DUALEN  = 0;  // dual_processing_enable in 0x79
  localparam int DRD_B_A0      = 0;  // chain_a_stages[0] in 0x7a
  localparam int DRD_B_SKEWEN  = 7;  // skew_correction_enable in 0x7a
  localparam int DRD_B_VAR     = 0;  // skew_variant_select in 0x81
  localparam int DRD_B_OCTSEL  = 1;  // octal_processing_select in 0x81
  localparam int DRD_B_BAND    = 2;  // nyquist_band_select in 0x81
  localparam int DRD_B_CW      = 2;  // cw octal mode in mode reg
  localparam int DRD_B_IQ      = 3;  // i/q input in mode reg
  localparam int DRD_B_W16     = 4;  // 16-bit output mode in mode reg
  // reset values
  localparam logic [7:0] DRD_RST_REG  = 8'h00;
  localparam logic [7:0] DRD_RST_MODE = 8'h10;  // single, 16-bit
  // timing and sizes
  localparam int DRD_SKEW_LAT = 59;  // skew correction processing cycles
  localparam int DRD_SW       = 16;  // core sample width
  localparam int DRD_XB       = 2;   // extra output lsbs
  localparam int DRD_NA       = 9;   // chain A stages
  localparam int DRD_NB       = 8;   // chain B stages
  // operating modes
  typedef enum logic [1:0] {DRD_SINGLE, DRD_DUAL, DRD_OCTAL} drd_mode_t;
  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } drd_apb_req_t;
endpackage : drd_pkg

// ===== src/drd_top.sv
`timescale 1ns/1ns
module drd_top
  import drd_pkg::*;
#(
  parameter int SW  = DRD_SW,        // core sample width
  parameter int LAT = DRD_SKEW_LAT,  // skew correction latency
  parameter int NA  = DRD_NA,        // chain A stage count
  parameter int NB  = DRD_NB         // chain B stage count
) (
  input  wire logic                    sys_clk,   // sample clock
  input  wire logic                    rst_b,     // async reset, active low
  input  wire drd_apb_req_t            apb_req,   // apb request
  output logic                         pready,    // apb ready
  output logic [31:0]                  prdata,    // apb read data
  output logic                         pslverr,   // apb error, unmapped or misaligned
  input  wire logic                    in_valid,  // core sample strobe
  input  wire logic signed [SW-1:0]    in_a,      // channel 1 or I data
  input  wire logic signed [SW-1:0]    in_b,      // channel 2 or Q data
  output logic                         out_valid, // output sample strobe
  output logic signed [SW+DRD_XB-1:0]  out_a,     // chain A word
  output logic signed [SW+DRD_XB-1:0]  out_b      // chain B word
);
  localparam int W = SW + DRD_XB;  // working width with fraction bits

  // one sample of both channels
  typedef struct packed {
    logic                v;
    logic signed [SW-1:0] a;
    logic signed [SW-1:0] b;
  } drd_smp_t;

  // whole module state
  typedef struct packed {
    logic [7:0]                res;      // output_resolution_control
    logic [7:0]                dual;     // dual_processing_enable
    logic [7:0]                ska;      // skew_fix_and_chain_a_low
    logic [7:0]                ahi;      // chain_a_high
    logic [7:0]                chb;      // chain_b_stages
    logic [7:0]                sel;      // skew_fix_mode_select
    logic [7:0]                mode;     // operating mode
    logic                      pready;   // apb ready
    logic [31:0]               prdata;   // apb read data
    logic                      pslverr;  // apb error
    logic signed [SW-1:0]      prev_b;   // previous channel 2 sample
    drd_smp_t [LAT-1:0]        dly;      // skew correction pipeline
    logic [NA-1:0]             pha;      // chain A stage phases
    logic [NA-1:0][W-1:0]      hola;     // chain A held samples
    logic [NB-1:0]             phb;      // chain B stage phases
    logic [NB-1:0][W-1:0]      holb;     // chain B held samples
    logic                      ov;       // output strobe
    logic [W-1:0]              oa;       // chain A output
    logic [W-1:0]              ob;       // chain B output
  } drd_st_t;

  drd_st_t q;       // registered state
  drd_st_t next_q;  // next state

  // true for every implemented register index
  function automatic logic idx_known(input logic [7:0] idx);
    idx_known = (idx == DRD_IDX_RES) || (idx == DRD_IDX_DUAL) ||
                (idx == DRD_IDX_SKA) || (idx == DRD_IDX_AHI) ||
                (idx == DRD_IDX_CHB) || (idx == DRD_IDX_SEL) ||
                (idx == DRD_IDX_MODE) || (idx == DRD_IDX_STAT);
  endfunction : idx_known

  // count of consecutive set bits from bit 0 (thermometer code)
  function automatic logic [3:0] therm_count(input logic [NA-1:0] f);
    logic run;
    therm_count = 4'h0;
    run = 1'b1;
    for (int i = 0; i < NA; i++) begin
      run = run & f[i];
      if (run) begin
        therm_count = therm_count + 4'h1;
      end
    end
  endfunction : therm_count

  // average of held and new sample, the halving filter of one stage
  function automatic logic [W-1:0] half_avg(input logic [W-1:0] h, input logic [W-1:0] x);
    logic signed [W:0] sum;
    sum = $signed({h[W-1], h}) + $signed({x[W-1], x});
    half_avg = sum[W:1];
  endfunction : half_avg

  // decoded configuration
  drd_mode_t          mode;       // operating mode
  logic               skew_on;    // skew correction active
  logic               dec_ok;     // decimation allowed in this mode
  logic [3:0]         rate_cnt;   // enabled stage count
  logic [NA-1:0]      ea;         // chain A stage enables
  logic [NB-1:0]      eb;         // chain B stage enables
  logic               use_b;      // chain B in service

  // configuration decode
  always_comb begin
    logic route_ok;
    route_ok = 1'b0;
    mode = drd_mode_t'(q.mode[1:0]);
    // channel-count bit routes to dual or octal processing
    if (mode == DRD_DUAL) begin
      route_ok = q.dual[DRD_B_DUALEN] && !q.sel[DRD_B_OCTSEL];
    end else if (mode == DRD_OCTAL) begin
      route_ok = q.sel[DRD_B_OCTSEL];
    end
    // never in single-channel mode
    skew_on = q.ska[DRD_B_SKEWEN] && (mode != DRD_SINGLE) && route_ok;
    // decimation in single, dual and cw octal only
    dec_ok = (mode == DRD_SINGLE) ||
             ((mode == DRD_DUAL) && q.dual[DRD_B_DUALEN]) ||
             ((mode == DRD_OCTAL) && q.mode[DRD_B_CW]);
    use_b = (mode == DRD_DUAL) || q.mode[DRD_B_IQ];
    ea = '0;
    eb = '0;
    rate_cnt = 4'h0;
    if (dec_ok) begin
      if (use_b) begin
        // stage 1A unused, rate from the upper eight bits, max 256x
        rate_cnt = therm_count({1'b0, q.ahi});
        for (int i = 0; i < NB; i++) begin
          ea[i+1] = (4'(i) < rate_cnt);
          eb[i]   = (4'(i) < rate_cnt);  // same rate both chains
        end
      end else begin
        // chain A alone, nine stages, max 512x
        rate_cnt = therm_count({q.ahi, q.ska[DRD_B_A0]});
        for (int i = 0; i < NA; i++) begin
          ea[i] = (4'(i) < rate_cnt);
        end
      end
    end
  end

  // next-state logic: apb slave, skew correction, decimation chains
  always_comb begin
    logic [7:0]           idx;
    logic [7:0]           rd;
    drd_smp_t             cur;
    drd_smp_t             src;
    logic signed [SW+1:0] t;
    logic                 va;
    logic                 vb;
    logic [W-1:0]         xa;
    logic [W-1:0]         xb;
    next_q = q;
    idx = apb_req.paddr[9:2];
    rd = 8'h00;
    t = '0;
    // apb: one wait state, answer in second access cycle
    next_q.pready = apb_req.psel && apb_req.penable && !q.pready;
    if (apb_req.psel && apb_req.penable && !q.pready) begin
      unique case (idx)
        DRD_IDX_RES:  rd = q.res;
        DRD_IDX_DUAL: rd = q.dual;
        DRD_IDX_SKA:  rd = q.ska;
        DRD_IDX_AHI:  rd = q.ahi;
        DRD_IDX_CHB:  rd = q.chb;
        DRD_IDX_SEL:  rd = q.sel;
        DRD_IDX_MODE: rd = q.mode;
        DRD_IDX_STAT: rd = {3'h0, skew_on, rate_cnt};  // block state
        default:      rd = 8'h00;                      // unmapped reads zero
      endcase
      // refused reads return zero
      if (!idx_known(idx) || (apb_req.paddr[1:0] != 2'h0)) begin
        rd = 8'h00;
      end
      next_q.prdata  = {24'h000000, rd};
      next_q.pslverr = !idx_known(idx) || (apb_req.paddr[1:0] != 2'h0);
    end
    // write takes effect at the completing edge
    if (apb_req.psel && apb_req.penable && q.pready && apb_req.pwrite &&
        !q.pslverr) begin
      unique case (idx)
        DRD_IDX_RES:  next_q.res  = apb_req.pwdata[7:0];
        DRD_IDX_DUAL: next_q.dual = apb_req.pwdata[7:0];
        DRD_IDX_SKA:  next_q.ska  = apb_req.pwdata[7:0];
        DRD_IDX_AHI:  next_q.ahi  = apb_req.pwdata[7:0];
        DRD_IDX_CHB:  next_q.chb  = apb_req.pwdata[7:0];
        DRD_IDX_SEL:  next_q.sel  = apb_req.pwdata[7:0];
        DRD_IDX_MODE: next_q.mode = apb_req.pwdata[7:0];
        default:      ;  // status and unmapped: no effect
      endcase
    end

    // skew correction on channel 2 ahead of all else
    cur.v = in_valid;
    cur.a = in_a;
    cur.b = in_b;
    if (in_valid) begin
      next_q.prev_b = in_b;
      if (q.sel[DRD_B_VAR]) begin
        // octal variant: quarter-sample interpolation
        t = 18'(3 * in_b) + 18'(q.prev_b);
        cur.b = t[SW+1:2];
      end else if (q.sel[DRD_B_BAND]) begin
        // second nyquist band response, dual variant only
        t = 18'(in_b) - 18'(q.prev_b);
        cur.b = t[SW:1];
      end else begin
        // dual variant, first band: half-sample interpolation
        t = 18'(in_b) + 18'(q.prev_b);
        cur.b = t[SW:1];
      end
    end
    // fixed processing pipeline of LAT cycles
    next_q.dly = {q.dly[LAT-2:0], cur};
    // bypass adds no latency when correction is off
    src = skew_on ? q.dly[LAT-1] : drd_smp_t'({in_valid, in_a, in_b});

    // i data on chain A, q data on chain B
    va = src.v;
    vb = src.v && use_b;
    xa = {src.a, {DRD_XB{1'b0}}};
    xb = {src.b, {DRD_XB{1'b0}}};
    // chain A cascade, each stage halves the rate
    for (int i = 0; i < NA; i++) begin
      if (!ea[i]) begin
        next_q.pha[i] = 1'b0;  // disabled stage passes through
      end else if (va) begin
        if (!q.pha[i]) begin
          next_q.hola[i] = xa;  // first of pair held
          next_q.pha[i] = 1'b1;
          va = 1'b0;
        end else begin
          xa = half_avg(q.hola[i], xa);  // pair yields one sample
          next_q.pha[i] = 1'b0;
        end
      end
    end
    // chain B cascade, off unless dual mode or i/q input
    for (int i = 0; i < NB; i++) begin
      if (!eb[i]) begin
        next_q.phb[i] = 1'b0;
      end else if (vb) begin
        if (!q.phb[i]) begin
          next_q.holb[i] = xb;
          next_q.phb[i] = 1'b1;
          vb = 1'b0;
        end else begin
          xb = half_avg(q.holb[i], xb);
          next_q.phb[i] = 1'b0;
        end
      end
    end
    // output register, strobe qualifies each sample
    next_q.ov = va;
    if (va) begin
      next_q.oa = xa;
      next_q.ob = use_b ? xb : '0;
      // 18-bit words only with extra lsbs in 16-bit mode
      if (!(q.res[DRD_B_XLSB] && q.mode[DRD_B_W16])) begin
        next_q.oa[DRD_XB-1:0] = '0;
        next_q.ob[DRD_XB-1:0] = '0;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.mode <= DRD_RST_MODE;
      q.res  <= DRD_RST_REG;
    end else begin
      q <= next_q;
    end
  end

  // outputs from state flops, pslverr gated with pready
  assign pready    = q.pready;
  assign prdata    = q.prdata;
  assign pslverr   = q.pslverr && q.pready;
  assign out_valid = q.ov;
  assign out_a     = q.oa;
  assign out_b     = q.ob;
endmodule : drd_top
